// [ris_sequencer.v]
`include "ris_regs.vh"

module ris_sequencer #(
    parameter IN_MIN     = `RIS_IN_MIN_CYC,
    parameter OUT_ASSERT = `RIS_OUT_ASSERT_CYC,
    parameter H2S_GAP    = `RIS_HRST_TO_SRST,
    parameter CFG_ON     = `RIS_CFG_ON_CYC
) (
    input  wire                  clk,
    input  wire                  nrst,
    input  wire                  power_on_reset_n,
    input  wire                  hard_reset_in_n,
    input  wire                  soft_reset_in_n,
    input  wire [`RIS_SRC_W-1:0] cfg_reset_source_in,
    input  wire                  input_clock_divide_select,
    output reg                   hard_reset_n_out,
    output reg                   hard_reset_n_oe,
    output reg                   soft_reset_n_out,
    output reg                   soft_reset_n_oe,
    output reg                   cfg_pins_oe,
    output reg  [`RIS_SRC_W-1:0] cfg_reset_source,
    output reg                   cfg_clock_divide,
    output reg                   reset_flow_active
);

    // =================================================================
    // States of the reset flow.
    // Both outputs driven, hard released with soft still driven, the
    // wait for idle inputs, and the soft-only flow. The idle state ends
    // the flow and arms the input timers again.
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_BOTH  = 5'h02;
    localparam [4:0] ST_SOFT  = 5'h04;
    localparam [4:0] ST_CFGW  = 5'h08;
    localparam [4:0] ST_SOFTO = 5'h10;

    // =================================================================
    // Two-stage synchronisers for pins from outside the clock domain.
    // Only the second stage is read by logic, so a metastable first
    // stage never reaches the counters or the state machine.
    reg [2:0]            sync1;
    reg [2:0]            sync2;
    reg [`RIS_SRC_W:0]   strap1;
    reg [`RIS_SRC_W:0]   strap2;
    reg                  por_prev;
    reg [`RIS_CNT_W-1:0] in_cnt;
    reg [`RIS_CNT_W-1:0] por_cnt;
    reg [`RIS_CNT_W-1:0] seq_cnt;
    reg [4:0]            state;

    wire por_n  = sync2[0];
    wire hrst_n = sync2[1];
    wire srst_n = sync2[2];

    // Pin inputs are retimed through two flip-flops.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1  <= 3'h7;
            sync2  <= 3'h7;
            strap1 <= 4'h0;
            strap2 <= 4'h0;
        end else begin
            sync1  <= {soft_reset_in_n, hard_reset_in_n, power_on_reset_n};
            sync2  <= sync1;
            strap1 <= {input_clock_divide_select, cfg_reset_source_in};
            strap2 <= strap1;
        end
    end

    // Straps are captured when power-on reset negates after a valid hold.
    // A power-on pulse shorter than the minimum keeps the old straps, so
    // a glitch on the supervisor output cannot load a random setting.
    // In host mode this clock is the sync clock derived from the primary
    // clock by the divider that the captured divide bit chooses.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            por_prev         <= 1'b1; // Matches the idle pin level.
            por_cnt          <= {`RIS_CNT_W{1'b0}};
            cfg_reset_source <= {`RIS_SRC_W{1'b0}};
            cfg_clock_divide <= 1'b0;
        end else begin
            por_prev <= por_n;
            if (!por_n) begin
                if (por_cnt != IN_MIN[`RIS_CNT_W-1:0])
                    por_cnt <= por_cnt + 1'b1;
            end else begin
                por_cnt <= {`RIS_CNT_W{1'b0}};
            end
            if (por_n && !por_prev &&
                por_cnt == IN_MIN[`RIS_CNT_W-1:0]) begin
                cfg_reset_source <= strap2[`RIS_SRC_W-1:0];
                cfg_clock_divide <= strap2[`RIS_SRC_W];
            end
        end
    end

    // Hard and soft input assertion is timed; a short pulse is ignored.
    // The count only runs in the idle state: while a flow is busy the
    // device drives these pins itself, and its own drive must not be
    // mistaken for a new request.
    wire any_in = !hrst_n || !srst_n;
    wire in_ok  = in_cnt == IN_MIN[`RIS_CNT_W-1:0];
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_cnt <= {`RIS_CNT_W{1'b0}};
        end else if (any_in && state == ST_IDLE) begin
            if (!in_ok)
                in_cnt <= in_cnt + 1'b1;
        end else begin
            in_cnt <= {`RIS_CNT_W{1'b0}};
        end
    end

    // =================================================================
    // Output sequencer: hard release, straps re-driven, then soft release.
    // The outputs are open-drain: a driven output is low with its enable
    // high, and a released output lets the board pull-up take the pin.
    // Reset starts a full flow, so the device leaves reset cleanly.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state             <= ST_BOTH;
            seq_cnt           <= {`RIS_CNT_W{1'b0}};
            hard_reset_n_out  <= 1'b0;
            hard_reset_n_oe   <= 1'b1;
            soft_reset_n_out  <= 1'b0;
            soft_reset_n_oe   <= 1'b1;
            cfg_pins_oe       <= 1'b0;
            reset_flow_active <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    reset_flow_active <= 1'b0;
                    if (!por_n) begin
                        state <= ST_BOTH;
                    end else if (in_ok) begin
                        // A soft-only request leaves hard reset alone.
                        state <= hrst_n ? ST_SOFTO : ST_BOTH;
                    end
                    seq_cnt <= {`RIS_CNT_W{1'b0}};
                    if (!por_n || in_ok) begin
                        reset_flow_active <= 1'b1;
                        soft_reset_n_out  <= 1'b0;
                        soft_reset_n_oe   <= 1'b1;
                        if (!por_n || !hrst_n) begin
                            hard_reset_n_out <= 1'b0;
                            hard_reset_n_oe  <= 1'b1;
                            cfg_pins_oe      <= 1'b0;
                        end
                    end
                end
                ST_BOTH: begin
                    // Power-on reset held low keeps the count at zero,
                    // so the full assertion time follows its negation.
                    cfg_pins_oe <= 1'b0;
                    if (!por_n)
                        seq_cnt <= {`RIS_CNT_W{1'b0}};
                    else if (seq_cnt ==
                             OUT_ASSERT[`RIS_CNT_W-1:0] - 1'b1) begin
                        hard_reset_n_out <= 1'b1;
                        hard_reset_n_oe  <= 1'b0;
                        seq_cnt <= {`RIS_CNT_W{1'b0}};
                        state   <= ST_SOFT;
                    end else
                        seq_cnt <= seq_cnt + 1'b1;
                end
                ST_SOFT: begin
                    // Hard reset is released here; the strap pins are
                    // driven again one clock later and soft reset stays
                    // driven until the gap has been counted.
                    if (seq_cnt == CFG_ON[`RIS_CNT_W-1:0] - 1'b1)
                        cfg_pins_oe <= 1'b1;
                    if (seq_cnt == H2S_GAP[`RIS_CNT_W-1:0] - 1'b1) begin
                        soft_reset_n_out <= 1'b1;
                        soft_reset_n_oe  <= 1'b0;
                        state <= ST_CFGW;
                    end
                    seq_cnt <= seq_cnt + 1'b1;
                end
                ST_SOFTO: begin
                    // Soft-only flow: hard reset and straps are untouched
                    // and soft reset is driven for the full time.
                    if (seq_cnt == OUT_ASSERT[`RIS_CNT_W-1:0] - 1'b1) begin
                        soft_reset_n_out <= 1'b1;
                        soft_reset_n_oe  <= 1'b0;
                        state <= ST_CFGW;
                    end
                    seq_cnt <= seq_cnt + 1'b1;
                end
                ST_CFGW: begin
                    // Wait for the inputs to go idle before rearming.
                    cfg_pins_oe <= 1'b1;
                    if (!any_in) state <= ST_IDLE;
                end
                default: begin
                    state <= ST_BOTH;
                end
            endcase
            // Power-on reset low outranks every other state: the flow
            // restarts with both outputs driven and the strap pins
            // released, so the full assertion time is counted again.
            if (!por_n && state != ST_IDLE) begin
                state             <= ST_BOTH;
                seq_cnt           <= {`RIS_CNT_W{1'b0}};
                hard_reset_n_out  <= 1'b0;
                hard_reset_n_oe   <= 1'b1;
                soft_reset_n_out  <= 1'b0;
                soft_reset_n_oe   <= 1'b1;
                cfg_pins_oe       <= 1'b0;
                reset_flow_active <= 1'b1;
            end
        end
    end

endmodule // ris_sequencer

// [ris_regs.vh]
`ifndef RIS_REGS_VH
`define RIS_REGS_VH
// =====================================================================
// Reset sequencing timing counts, in periods of the sync clock, then the counter and strap field widths in bits.
`define RIS_IN_MIN_CYC      32
`define RIS_OUT_ASSERT_CYC  512
`define RIS_HRST_TO_SRST    16
`define RIS_CFG_ON_CYC      1
`define RIS_CFG_SETUP_CYC   4
`define RIS_CNT_W           10
`define RIS_SRC_W           3
`endif

// [ris_chk.sv]
// ========================================
// Reset sequencer checker
module ris_chk #(
    parameter IN_MIN     = 32,
    parameter OUT_ASSERT = 512
) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       power_on_reset_n,
    input wire logic       hard_reset_in_n,
    input wire logic       soft_reset_in_n,
    input wire logic       hard_reset_n_out,
    input wire logic       hard_reset_n_oe,
    input wire logic       soft_reset_n_oe,
    input wire logic       cfg_pins_oe,
    input wire logic [2:0] cfg_reset_source,
    input wire logic       cfg_clock_divide,
    input wire logic       reset_flow_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] low_cnt;
    logic [15:0] hold_cnt;
    wire         any_low = !(hard_reset_in_n && soft_reset_in_n);
    // Counts input low time and hard drive time.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt  <= 16'h0;
            hold_cnt <= 16'h0;
        end else begin
            low_cnt  <= any_low ? low_cnt + 16'h1 : 16'h0;
            hold_cnt <= hard_reset_n_oe ? hold_cnt + 16'h1 : 16'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    hold_min_a: assert property ($fell(hard_reset_n_oe) |->
        hold_cnt >= OUT_ASSERT) else $error("hard drive too short");
    drive_low_a: assert property (hard_reset_n_oe |->
        !hard_reset_n_out) else $error("hard drive not low");
    soft_gap_a: assert property ($fell(hard_reset_n_oe) |->
        soft_reset_n_oe [*4]) else $error("soft released early");
    cfg_on_a: assert property ($rose(cfg_pins_oe) |->
        !$past(hard_reset_n_oe)) else $error("straps driven early");
    cfg_off_a: assert property ($rose(hard_reset_n_oe) |=>
        !cfg_pins_oe) else $error("straps driven in reset");
    strap_hold_a: assert property ($changed({cfg_clock_divide,
        cfg_reset_source}) |-> hard_reset_n_oe) else $error("strap moved");
    start_min_a: assert property ($rose(reset_flow_active) &&
        power_on_reset_n |-> low_cnt >= IN_MIN)
        else $error("flow started early");
endmodule // ris_chk

// [ris_board.sv]
// ========================================
// Board reset supervisor and strap model
module ris_board (
    input  wire logic       clk,
    input  wire logic       cfg_pins_oe,
    output logic            por_n = 1'b1,
    output logic            hard_n = 1'b1,
    output logic            soft_n = 1'b1,
    output logic [2:0]      src,
    output logic            div
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] src_r = 3'h0;
    logic       div_r = 1'b0;
    // Straps read inverted once the device takes the pins back.
    assign src = cfg_pins_oe ? ~src_r : src_r;
    assign div = cfg_pins_oe ? ~div_r : div_r;
    // Holds one reset input low for n clocks, straps set beforehand.
    task automatic pulse(input int which, input int n, input logic [3:0] s);
        @(posedge clk);
        {div_r, src_r} <= s;
        repeat (4) @(posedge clk);
        if (which == 0) por_n <= 1'b0;
        else if (which == 1) hard_n <= 1'b0;
        else soft_n <= 1'b0;
        repeat (n) @(posedge clk);
        {por_n, hard_n, soft_n} <= 3'h7;
    endtask
endmodule // ris_board

// [tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       por_n, hard_n, soft_n, div, hoe, hout, soe, sout, cfg_oe;
    logic       div_q, act;
    logic [2:0] src, src_q;
    int         mismatches = 0;
    int         checks = 0;
    int         n;
    int         hrun = 0;
    int         srun = 0;
    int         hlen = 0;
    int         slen = 0;
    // Measures how many clocks each reset output was last driven.
    always @(posedge clk) begin
        if (hoe) hrun <= hrun + 1;
        else if (hrun != 0) begin
            hlen <= hrun;
            hrun <= 0;
        end
        if (soe) srun <= srun + 1;
        else if (srun != 0) begin
            slen <= srun;
            srun <= 0;
        end
    end
    // Open-drain pins resolve board and device drive.
    wire hard_pin = hard_n & (hoe ? hout : 1'b1);
    wire soft_pin = soft_n & (soe ? sout : 1'b1);
    ris_board ris_board_i (.clk(clk), .cfg_pins_oe(cfg_oe), .por_n(por_n),
        .hard_n(hard_n), .soft_n(soft_n), .src(src), .div(div));
    ris_sequencer #(.IN_MIN(4), .OUT_ASSERT(16), .H2S_GAP(4), .CFG_ON(1))
    ris_sequencer_i (.clk(clk), .nrst(nrst), .power_on_reset_n(por_n),
        .hard_reset_in_n(hard_pin), .soft_reset_in_n(soft_pin),
        .cfg_reset_source_in(src), .input_clock_divide_select(div),
        .hard_reset_n_out(hout), .hard_reset_n_oe(hoe),
        .soft_reset_n_out(sout), .soft_reset_n_oe(soe),
        .cfg_pins_oe(cfg_oe), .cfg_reset_source(src_q),
        .cfg_clock_divide(div_q), .reset_flow_active(act));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Counts clocks until hard drive, soft drive or flow reaches v.
    task automatic waitv(input int s, input logic v, output int c);
        c = 0;
        while ((s == 0 ? hoe : s == 1 ? soe : act) !== v && c < 300) begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Makes the 200 MHz clock.
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Cuts a hung run short.
    initial begin
        #20000;
        mismatches++;
        end_of_test();
    end
    // Runs the scenarios in turn.
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        waitv(2, 1'b0, n);
        ris_board_i.pulse(0, 8, 4'hD);
        waitv(2, 1'b0, n);
        chk({div_q, src_q}, 8'h0D);
        ris_board_i.pulse(1, 2, 4'h2);
        repeat (10) @(posedge clk);
        chk(act, 1'b0);
        ris_board_i.pulse(1, 8, 4'h2);
        waitv(0, 1'b1, n);
        chk(hout, 1'b0);
        waitv(0, 1'b0, n);
        chk(cfg_oe, 1'b0);
        waitv(1, 1'b0, n);
        chk(n, 8'd4);
        chk(cfg_oe, 1'b1);
        chk(hlen, 8'd16);
        waitv(2, 1'b0, n);
        chk({div_q, src_q}, 8'h0D);
        ris_board_i.pulse(2, 8, 4'h2);
        waitv(1, 1'b1, n);
        chk(hoe, 1'b0);
        chk(sout, 1'b0);
        waitv(1, 1'b0, n);
        waitv(2, 1'b0, n);
        chk(slen, 8'd16);
        end_of_test();
    end
endmodule // tb_top
bind ris_sequencer ris_chk #(.IN_MIN(IN_MIN), .OUT_ASSERT(OUT_ASSERT))
ris_chk_i (.clk(clk), .nrst(nrst), .power_on_reset_n(power_on_reset_n),
    .hard_reset_in_n(hard_reset_in_n), .soft_reset_in_n(soft_reset_in_n),
    .hard_reset_n_out(hard_reset_n_out), .hard_reset_n_oe(hard_reset_n_oe),
    .soft_reset_n_oe(soft_reset_n_oe), .cfg_pins_oe(cfg_pins_oe),
    .cfg_reset_source(cfg_reset_source), .cfg_clock_divide(cfg_clock_divide),
    .reset_flow_active(reset_flow_active));
